/* bdat_transmitter.sv */
// Bi-phase mark digital audio transmitter: subframes, blocks, preambles, channel status.
// Assumes all inputs come from decoder logic on core_clk_in, so none is synchronised.
// Operation
// - Three modes: low, pre-concealment, post-concealment
// - Subframes of 32 bits in bi-phase mark
// - Blocks of 384 subframes, count restarts
// - Bits 0-3 carry coding-violating sync
// - B starts block, M other left, W right
// - Auxiliary bits 4-7 normally zero
// - Bit 4 optionally carries correction flags
// - Audio bits 8-27, sample at 12-27
// - Left and right subframes strictly alternate
// - Validity bit 28 marks uncorrectable samples
// - User bit 29 carries unaligned subcode stream
// - Channel status equal across a pair, save bits 28-29 if clock accuracy changes mid-pair
// - Bit 31 is even parity of 4-30
// - Status bits 0-3 copy subcode control
// - Category bits 8-15: only bit 8 set
// - Status bits 28-29 give clock accuracy
// - Remaining status bits always zero
module bdat_transmitter (
  input  wire logic                        core_clk_in,
  input  wire logic                        rst_b_in,
  input  wire bdat_pkg::bdat_mode_type     source_mode_in,
  input  wire bdat_pkg::bdat_accuracy_type clock_accuracy_in,
  input  wire logic                        flag_insert_in,
  input  wire logic [3:0]                  q_control_in,
  input  wire logic                        user_bit_in,
  input  wire logic                        pair_valid_in,
  input  wire bdat_pkg::bdat_pair_type     pair_in,
  output logic                             pair_ready_out,
  output logic                             user_take_out,
  output logic                             block_start_out,
  output logic                             underrun_out,
  output logic                             biphase_audio_out_pin_out
);

  // Channel-status content for one status index
  function automatic logic cs_bit(input logic [bdat_pkg::CS_IDX_W-1:0] idx,
                                  input logic [3:0]                    q,
                                  input bdat_pkg::bdat_accuracy_type   acc);
    logic result;
    result = 1'b0;
    if (idx < bdat_pkg::CS_CTRL_END) begin
      result = q[idx[1:0]];
    end else if (idx == bdat_pkg::CS_CATEGORY) begin
      result = 1'b1;
    end else if (idx == bdat_pkg::CS_ACC_LO) begin
      result = acc == bdat_pkg::BDAT_ACC_LEVEL_I;
    end else if (idx == bdat_pkg::CS_ACC_HI) begin
      result = acc == bdat_pkg::BDAT_ACC_LEVEL_III;
    end
    return result;
  endfunction

  // Half-cell pacing
  logic [bdat_pkg::ACC_W-1:0]     acc;
  // Position of the half-cell on the line
  logic                           half;
  logic [bdat_pkg::BIT_IDX_W-1:0] bit_idx;
  logic [bdat_pkg::SUB_IDX_W-1:0] sub_idx;
  // Subframe being sent and its preamble
  logic [bdat_pkg::SUBFRAME_BITS-1:0] word;
  logic [bdat_pkg::PRE_W-1:0]     pat;
  logic                           sync_base;
  logic                           level;
  // Right half of the current pair and the latched control bits
  bdat_pkg::bdat_pair_type        held;
  logic                           held_ok;
  logic [3:0]                     qctl;

  logic                           buf_valid;
  bdat_pkg::bdat_pair_type        buf_data;

  // Half-cell tick: fractional divide of 40 MHz to 128 x 44.1 kHz
  wire [bdat_pkg::ACC_W-1:0] acc_sum  = acc + bdat_pkg::ACC_STEP;
  wire                       tick     = acc_sum >= bdat_pkg::ACC_MODULUS;
  wire [bdat_pkg::ACC_W-1:0] next_acc = tick ? acc_sum - bdat_pkg::ACC_MODULUS : acc_sum;

  // Next position; the subframe ends after the second half of bit 31
  wire                           at_end   = half & (bit_idx == bdat_pkg::LAST_BIT);
  wire                           next_half = ~half;
  wire [bdat_pkg::BIT_IDX_W-1:0] next_bit = half ? bit_idx + 5'h01 : bit_idx;
  wire [bdat_pkg::SUB_IDX_W-1:0] sub_inc  = (sub_idx == bdat_pkg::LAST_SUB) ? bdat_pkg::FIRST_SUB
                                                                            : sub_idx + 9'h001;
  wire [bdat_pkg::SUB_IDX_W-1:0] next_sub = at_end ? sub_inc : sub_idx;
  wire                           next_left = ~next_sub[0];
  wire                           boundary = tick & at_end;

  // Pair selection; an empty buffer at a left subframe sends silence marked invalid
  wire                     pop      = boundary & next_left;
  wire                     underrun = next_left & ~buf_valid;
  wire bdat_pkg::bdat_pair_type src = next_left ? buf_data : held;
  wire                     src_ok   = next_left ? buf_valid : held_ok;
  wire                     use_post = source_mode_in == bdat_pkg::BDAT_MODE_POST;

  wire [bdat_pkg::SAMPLE_W-1:0] pre_sample  = next_left ? src.pre_left : src.pre_right;
  wire [bdat_pkg::SAMPLE_W-1:0] post_sample = next_left ? src.post_left : src.post_right;
  wire [bdat_pkg::SAMPLE_W-1:0] sample      = ~src_ok ? '0 : use_post ? post_sample : pre_sample;
  // Validity is taken from the decoder flag in both data modes
  wire bad_bit  = ~src_ok | (next_left ? src.left_bad : src.right_bad);
  wire flag_bit = src_ok & flag_insert_in & (next_left ? src.left_flag : src.right_flag);

  // Both subframes of a pair share one status index
  wire [bdat_pkg::CS_IDX_W-1:0] cs_idx = next_sub[bdat_pkg::SUB_IDX_W-1:1];
  wire [3:0] q_now   = (next_sub == bdat_pkg::FIRST_SUB) ? q_control_in : qctl;
  wire       cs_val  = cs_bit(cs_idx, q_now, clock_accuracy_in);

  // Body is bits 4 to 30, lsb first on the line
  wire [bdat_pkg::BODY_W-1:0] body = {
    cs_val,
    user_bit_in,
    bad_bit,
    sample,
    {bdat_pkg::PAD_ZERO_W{1'b0}},
    {bdat_pkg::AUX_ZERO_W{1'b0}},
    flag_bit
  };
  wire                                parity     = ^body;
  wire [bdat_pkg::SUBFRAME_BITS-1:0]  next_word  = {parity, body, {bdat_pkg::SYNC_BITS{1'b0}}};
  wire [bdat_pkg::SUBFRAME_BITS-1:0]  use_word   = at_end ? next_word : word;

  // Preamble choice for the subframe that starts at the boundary
  wire [bdat_pkg::PRE_W-1:0] sel_pat = ~next_left                      ? bdat_pkg::PRE_W_PAT
                                     : (next_sub == bdat_pkg::FIRST_SUB) ? bdat_pkg::PRE_B
                                                                         : bdat_pkg::PRE_M;
  wire [bdat_pkg::PRE_W-1:0] use_pat  = at_end ? sel_pat : pat;
  wire                       use_base = at_end ? level : sync_base;
  wire [2:0]                 pre_pos  = {next_bit[1:0], next_half};
  wire                       in_sync  = next_bit < bdat_pkg::SYNC_BITS;
  wire                       sync_lvl = use_pat[bdat_pkg::PRE_MSB - pre_pos] ^ use_base;

  // Bi-phase mark: every cell starts with a change, a one adds one mid-cell
  wire data_lvl   = ~next_half ? ~level : (use_word[next_bit] ? ~level : level);
  wire line_lvl   = in_sync ? sync_lvl : data_lvl;
  wire next_level = tick ? line_lvl : level;
  wire pin_off    = source_mode_in == bdat_pkg::BDAT_MODE_OFF;

  bdat_pair_buf u_pair_buf (
    .core_clk_in   (core_clk_in),
    .rst_b_in      (rst_b_in),
    .in_valid_in   (pair_valid_in),
    .in_data_in    (pair_in),
    .in_ready_out  (pair_ready_out),
    .out_valid_out (buf_valid),
    .out_data_out  (buf_data),
    .out_ready_in  (pop)
  );

  // Pacing and position
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      acc     <= '0;
      half    <= 1'b1;
      bit_idx <= bdat_pkg::LAST_BIT;
      sub_idx <= bdat_pkg::LAST_SUB;
    end else begin
      acc <= next_acc;
      if (tick) begin
        half    <= next_half;
        bit_idx <= next_bit;
        sub_idx <= next_sub;
      end
    end
  end

  // Subframe content latched at each boundary
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      word      <= '0;
      pat       <= bdat_pkg::PRE_B;
      sync_base <= 1'b0;
      held      <= '0;
      held_ok   <= 1'b0;
      qctl      <= 4'h0;
    end else if (boundary) begin
      word      <= next_word;
      pat       <= sel_pat;
      sync_base <= level;
      if (next_left) begin
        held    <= buf_data;
        held_ok <= buf_valid;
      end
      if (next_sub == bdat_pkg::FIRST_SUB) begin
        qctl    <= q_control_in;
      end
    end
  end

  // Line level and status pulses
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      level                     <= 1'b0;
      biphase_audio_out_pin_out <= 1'b0;
      user_take_out             <= 1'b0;
      block_start_out           <= 1'b0;
      underrun_out              <= 1'b0;
    end else begin
      level                     <= next_level;
      // The coder keeps running while the pin is held, so a mode change resumes in step
      biphase_audio_out_pin_out <= next_level & ~pin_off;
      user_take_out             <= boundary;
      block_start_out           <= boundary & (next_sub == bdat_pkg::FIRST_SUB);
      underrun_out              <= pop & underrun;
    end
  end

endmodule

/* bdat_pkg.sv */
// Shared constants and types of the bi-phase digital audio transmitter.
// Assumes a single 40 MHz core clock and a 44.1 kHz stereo sample stream.
package bdat_pkg;

  // Core clock and half-cell rate
  localparam int unsigned        CLK_HZ                = 40_000_000;
  localparam int unsigned        SAMPLE_RATE_HZ        = 44_100;
  localparam int unsigned        HALF_CELLS_PER_SAMPLE = 128;
  localparam int unsigned        ACC_W                 = 27;
  localparam logic [ACC_W-1:0]   ACC_MODULUS           = ACC_W'(CLK_HZ);
  localparam logic [ACC_W-1:0]   ACC_STEP              = ACC_W'(SAMPLE_RATE_HZ * HALF_CELLS_PER_SAMPLE);

  // Subframe layout
  localparam int unsigned        SUBFRAME_BITS = 32;
  localparam int unsigned        BIT_IDX_W     = 5;
  localparam logic [4:0]         LAST_BIT      = 5'h1f;
  localparam logic [4:0]         SYNC_BITS     = 5'h04;
  localparam int unsigned        SAMPLE_W      = 16;
  localparam int unsigned        AUX_ZERO_W    = 3;
  localparam int unsigned        PAD_ZERO_W    = 4;
  localparam int unsigned        BODY_W        = 27;

  // Block layout
  localparam int unsigned        SUB_IDX_W     = 9;
  localparam logic [8:0]         LAST_SUB      = 9'h17f;
  localparam logic [8:0]         FIRST_SUB     = 9'h000;

  // Preambles as half-cell levels after a low cell, first half-cell in the msb
  localparam int unsigned        PRE_W         = 8;
  localparam logic [2:0]         PRE_MSB       = 3'h7;
  localparam logic [7:0]         PRE_B         = 8'he8;
  localparam logic [7:0]         PRE_M         = 8'he2;
  localparam logic [7:0]         PRE_W_PAT     = 8'he4;

  // Channel-status bit positions
  localparam int unsigned        CS_IDX_W      = 8;
  localparam logic [7:0]         CS_CTRL_END   = 8'h04;
  localparam logic [7:0]         CS_CATEGORY   = 8'h08;
  localparam logic [7:0]         CS_ACC_LO     = 8'h1c;
  localparam logic [7:0]         CS_ACC_HI     = 8'h1d;

  // Buffer geometry
  localparam int unsigned        BUF_DEPTH     = 2;

  typedef enum logic [1:0] {
    BDAT_MODE_OFF,
    BDAT_MODE_PRE,
    BDAT_MODE_POST
  } bdat_mode_type;

  typedef enum logic [1:0] {
    BDAT_ACC_LEVEL_I,
    BDAT_ACC_LEVEL_II,
    BDAT_ACC_LEVEL_III
  } bdat_accuracy_type;

  // One stereo pair, before and after concealment, with its flags
  typedef struct packed {
    logic [SAMPLE_W-1:0] pre_left;
    logic [SAMPLE_W-1:0] pre_right;
    logic [SAMPLE_W-1:0] post_left;
    logic [SAMPLE_W-1:0] post_right;
    logic                left_bad;
    logic                right_bad;
    logic                left_flag;
    logic                right_flag;
  } bdat_pair_type;

  localparam int unsigned        PAIR_W        = $bits(bdat_pair_type);

endpackage

/* bdat_pair_buf.sv */
// Two-entry buffer for stereo pairs between the sample source and the transmitter.
// Assumes the same clock on both sides; ready and valid come from flip-flops.
module bdat_pair_buf (
  input  wire logic                    core_clk_in,
  input  wire logic                    rst_b_in,
  input  wire logic                    in_valid_in,
  input  wire bdat_pkg::bdat_pair_type in_data_in,
  output logic                         in_ready_out,
  output logic                         out_valid_out,
  output bdat_pkg::bdat_pair_type      out_data_out,
  input  wire logic                    out_ready_in
);

  bdat_pkg::bdat_pair_type mem [bdat_pkg::BUF_DEPTH];
  logic                    wr_ptr;
  logic                    rd_ptr;
  logic [1:0]              count;

  wire                     push       = in_valid_in & in_ready_out;
  wire                     pop        = out_ready_in & out_valid_out;
  wire [1:0]               next_count = count + {1'b0, push} - {1'b0, pop};

  assign out_data_out = mem[rd_ptr];

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wr_ptr        <= 1'b0;
      rd_ptr        <= 1'b0;
      count         <= 2'h0;
      in_ready_out  <= 1'b0;
      out_valid_out <= 1'b0;
    end else begin
      wr_ptr        <= wr_ptr ^ push;
      rd_ptr        <= rd_ptr ^ pop;
      count         <= next_count;
      in_ready_out  <= next_count != 2'(bdat_pkg::BUF_DEPTH);
      out_valid_out <= next_count != 2'h0;
    end
  end

  // Storage needs no reset; valid guards every read
  always_ff @(posedge core_clk_in) begin
    if (push) begin
      mem[wr_ptr] <= in_data_in;
    end
  end

endmodule

/* bdat_tx_sva.sv */
// Checker of pin timing, subframe pacing, block wrap and buffer handshake.
// Assumes binding to bdat_transmitter, one clock domain.
module bdat_tx_sva (
  input wire logic                    core_clk_in,
  input wire logic                    rst_b_in,
  input wire bdat_pkg::bdat_mode_type source_mode_in,
  input wire logic                    pair_valid_in,
  input wire logic                    pair_ready_out,
  input wire logic                    user_take_out,
  input wire logic                    block_start_out,
  input wire logic                    underrun_out,
  input wire logic                    biphase_audio_out_pin_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [9:0] gap;
  logic [8:0] sub_idx;
  logic       seen;
  wire        off = source_mode_in == bdat_pkg::BDAT_MODE_OFF;
  wire        pin = biphase_audio_out_pin_out;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);
  // Gap saturates so an idle stretch cannot wrap into a legal value
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      gap <= 10'h000;
      sub_idx <= bdat_pkg::LAST_SUB;
      seen <= 1'b0;
    end else if (user_take_out) begin
      gap <= 10'h001;
      sub_idx <= block_start_out ? 9'h000 : sub_idx + 9'h001;
      seen <= 1'b1;
    end else if (gap != 10'h3ff) begin
      gap <= gap + 10'h001;
    end
  end
  sequence s_hold;
    ($stable(pin) || off)[*6];
  endsequence
  pin_off_low_a: assert property (off |=> !pin) else $error("pin high while off");
  cell_hold_a: assert property ($changed(pin) |=> s_hold) else $error("half-cell too short");
  cell_gap_a: assert property ($changed(pin) && !off |-> ##[1:24] ($changed(pin) || off))
    else $error("run longer than three half-cells");
  take_spacing_a: assert property (user_take_out && seen |-> gap inside {[10'd452:10'd455]})
    else $error("subframe length wrong");
  block_wrap_a: assert property (user_take_out |-> block_start_out == (sub_idx == bdat_pkg::LAST_SUB))
    else $error("block start misplaced");
  block_take_a: assert property (block_start_out |-> user_take_out) else $error("block start off boundary");
  underrun_left_a: assert property (underrun_out |-> user_take_out && sub_idx[0]) else $error("underrun on right");
  preamble_flip_a: assert property (user_take_out && !off && !$past(off) |-> $changed(pin))
    else $error("preamble without transition");
  ready_fall_a: assert property ($fell(pair_ready_out) |-> $past(pair_valid_in && pair_ready_out))
    else $error("ready fell without push");
endmodule

/* bdat_rx_model.sv */
// Receiver model on the bi-phase line: run lengths to half-cells, half-cells to subframes.
// Assumes the line moves on clock edges only, a half-cell being 7 or 8 clocks.
module bdat_rx_model (
  input  wire logic   core_clk_in,
  input  wire logic   rst_b_in,
  input  wire logic   line_in,
  output logic        sf_stb_out,
  output logic [1:0]  sf_kind_out,
  output logic [31:0] sf_word_out,
  output logic        sf_ok_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [63:0] hc;
  logic [31:0] word;
  logic [7:0]  pre;
  logic        lv;
  logic        last_lv;
  logic        ok;
  logic        synced;
  int          fill;
  int          run;
  int          n;
  always @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      fill = 0;
      run = 0;
      lv = 1'b0;
      last_lv = 1'b0;
      synced = 1'b0;
      sf_stb_out <= 1'b0;
    end else begin
      sf_stb_out <= 1'b0;
      if (line_in === lv) begin
        run++;
      end else begin
        n = (run + 3) / 7;
        // Only a preamble holds a three half-cell run, so it marks the frame edge
        if (n == 3 && fill == 64) begin
          for (int j = 0; j < 8; j++) pre[7 - j] = hc[j] ^ ~hc[0];
          ok = hc[0] != last_lv;
          word = 32'h0000_0000;
          for (int i = 4; i < 32; i++) begin
            word[i] = hc[2 * i] ^ hc[2 * i + 1];
            ok = ok & (hc[2 * i] != hc[2 * i - 1]);
          end
          last_lv = hc[63];
          fill = 0;
          sf_kind_out <= pre == bdat_pkg::PRE_B ? 2'd0 : pre == bdat_pkg::PRE_M ? 2'd1 :
                         pre == bdat_pkg::PRE_W_PAT ? 2'd2 : 2'd3;
          sf_word_out <= word;
          sf_ok_out <= ok;
          sf_stb_out <= 1'b1;
        end
        // The idle low stretch after reset is no half-cell; collect from the first frame edge on
        if (n == 3) synced = 1'b1;
        for (int k = 0; k < n && n <= 3 && fill < 64 && synced; k++) begin
          hc[fill] = lv;
          fill++;
        end
        lv = line_in;
        run = 1;
      end
    end
  end
endmodule

/* tb.sv */
// Bench: random pairs and controls in, decoded subframes compared with expectations.
// Assumes the receiver model on the pin and the checker bound to the transmitter.
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic                        core_clk_in, rst_b_in, flag_insert_in, user_bit_in, pair_valid_in, pair_ready_out;
  logic                        user_take_out, block_start_out, underrun_out, pin, sf_stb, sf_ok, started, ending, post;
  logic                        push_prev;
  logic [1:0]                  sf_kind;
  logic [3:0]                  q_control_in, q_lat;
  logic [8:0]                  sub;
  logic [31:0]                 sf_word, rnd;
  bdat_pkg::bdat_mode_type     source_mode_in;
  bdat_pkg::bdat_accuracy_type clock_accuracy_in;
  bdat_pkg::bdat_pair_type     pair_in, cur, pushq[$];
  logic [33:0]                 expq[$];
  int                          n_errors, n_tests, n_sub, cyc;
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic cs_bit(input int k, input logic [3:0] q, input int a);
    return k < 4 ? q[k[1:0]] : k == 8 ? 1'b1 : k == 28 ? a == 0 : k == 29 ? a == 2 : 1'b0;
  endfunction
  function automatic logic [33:0] sf_exp(input logic [1:0] kind, input logic [15:0] s, input logic bad, flg, usr, cs);
    logic [31:0] w;
    w = {1'b0, cs, usr, bad, s, 7'h00, flg, 4'h0};
    w[31] = ^w[30:4];
    return {kind, w};
  endfunction
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  bdat_transmitter dut (.core_clk_in, .rst_b_in, .source_mode_in, .clock_accuracy_in, .flag_insert_in,
    .q_control_in, .user_bit_in, .pair_valid_in, .pair_in, .pair_ready_out, .user_take_out, .block_start_out,
    .underrun_out, .biphase_audio_out_pin_out(pin));
  bdat_rx_model rx (.core_clk_in, .rst_b_in, .line_in(pin), .sf_stb_out(sf_stb), .sf_kind_out(sf_kind),
    .sf_word_out(sf_word), .sf_ok_out(sf_ok));
  initial begin
    core_clk_in = 1'b0;
    forever #12.5 core_clk_in = ~core_clk_in;
  end
  always @(posedge core_clk_in) begin
    if (rst_b_in && sf_stb && expq.size() > 0) begin
      chk("sync kind", 32'(expq[0][33:32]), 32'(sf_kind));
      chk("subframe", expq[0][31:0], sf_word);
      chk("coding", 32'd1, 32'(sf_ok));
      void'(expq.pop_front());
      n_sub++;
    end
    if (rst_b_in && user_take_out) begin
      sub = block_start_out ? 9'h000 : sub + 9'h001;
      if (block_start_out) begin
        started = 1'b1;
        q_lat = q_control_in;
        q_control_in <= rnd[11:8];
      end
      // Pop before push below: a pair taken at this edge cannot feed this subframe
      if (started && !sub[0]) begin
        cur = '0;
        cur.left_bad = 1'b1;
        cur.right_bad = 1'b1;
        // A pair pushed at the boundary edge itself is not yet in the buffer
        chk("underrun", 32'(pushq.size() == int'(push_prev)), 32'(underrun_out));
        if (pushq.size() > int'(push_prev)) cur = pushq.pop_front();
      end
      post = source_mode_in == bdat_pkg::BDAT_MODE_POST;
      if (started) expq.push_back(sf_exp(sub == 9'h000 ? 2'd0 : sub[0] ? 2'd2 : 2'd1,
        sub[0] ? (post ? cur.post_right : cur.pre_right) : (post ? cur.post_left : cur.pre_left),
        sub[0] ? cur.right_bad : cur.left_bad, flag_insert_in & (sub[0] ? cur.right_flag : cur.left_flag),
        user_bit_in, cs_bit(int'(sub) / 2, q_lat, int'(clock_accuracy_in))));
      rnd = lfsr(rnd);
      user_bit_in <= rnd[0];
      flag_insert_in <= rnd[1];
      if (!ending) source_mode_in <= bdat_pkg::bdat_mode_type'(2'(rnd[3:2] % 3 + 1));
      // Accuracy moves only between pairs; level I lands on status bit 28, level III on 29
      if (sub[0]) clock_accuracy_in <= bdat_pkg::bdat_accuracy_type'(2'((int'(sub) + 2) % 3));
    end
    if (rst_b_in) begin
      push_prev = pair_valid_in && pair_ready_out;
      if (push_prev) pushq.push_back(pair_in);
      if (!pair_valid_in || pair_ready_out) begin
        rnd = lfsr(rnd);
        pair_in <= {rnd, lfsr(rnd), rnd[9:6]};
        pair_valid_in <= !(started && sub > 9'd99 && sub < 9'd112);
      end
    end
  end
  initial begin
    rst_b_in = 1'b0;
    pair_valid_in = 1'b0;
    pair_in = '0;
    user_bit_in = 1'b0;
    flag_insert_in = 1'b1;
    q_control_in = 4'hc;
    source_mode_in = bdat_pkg::BDAT_MODE_PRE;
    clock_accuracy_in = bdat_pkg::BDAT_ACC_LEVEL_II;
    rnd = 32'h0001_4c1d;
    push_prev = 1'b0;
    sub = 9'h000;
    started = 1'b0;
    ending = 1'b0;
    n_errors = 0;
    n_tests = 0;
    n_sub = 0;
    repeat (4) @(posedge core_clk_in);
    rst_b_in <= 1'b1;
    for (cyc = 0; cyc < 250000 && n_sub < 390; cyc++) @(posedge core_clk_in);
    if (n_sub < 390) chk("decoded subframes", 32'd390, 32'(n_sub));
    ending = 1'b1;
    source_mode_in <= bdat_pkg::BDAT_MODE_OFF;
    repeat (2) @(posedge core_clk_in);
    for (cyc = 0; cyc < 500; cyc++) begin
      @(posedge core_clk_in);
      chk("pin while off", 32'd0, 32'(pin));
    end
    close_out();
  end
endmodule
bind bdat_transmitter bdat_tx_sva u_sva (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in),
  .source_mode_in(source_mode_in), .pair_valid_in(pair_valid_in), .pair_ready_out(pair_ready_out),
  .user_take_out(user_take_out), .block_start_out(block_start_out), .underrun_out(underrun_out),
  .biphase_audio_out_pin_out(biphase_audio_out_pin_out));
